//--- logic/oag_pkg.sv
// constants and types shared by the operand address generator
package oag_pkg;
  // register word offsets on the avalon slave (byte addresses)
  localparam logic [3:0] OFS_TABLE_PAGE  = 4'h0;
  localparam logic [3:0] OFS_VIS_PAGE    = 4'h4;
  localparam logic [3:0] OFS_CONTROL     = 4'h8;
  localparam logic [3:0] OFS_STATUS      = 4'hc;
  // reset values
  localparam logic [7:0] RST_TABLE_PAGE  = 8'h00;
  localparam logic [7:0] RST_VIS_PAGE    = 8'h00;
  localparam logic       RST_WIN_EN      = 1'b0;
  // field positions
  localparam int CTL_WIN_EN_BIT    = 0;
  localparam int STS_WR_REFUSE_BIT = 24;
  localparam int STS_CFG_BIT       = 25;
  localparam int STS_WIN_BIT       = 26;
  localparam int PAGE_CFG_BIT      = 7;
  // widths
  localparam int DATA_W    = 16;
  localparam int PROG_W    = 24;
  localparam int NEAR_W    = 13;
  localparam int LIT5_W    = 5;
  localparam int HOLD_W    = 14;
  localparam int JUMP_W    = 16;
  localparam int REG_SEL_W = 4;
  // step sizes of pointer modification
  localparam logic [15:0] STEP_BYTE = 16'h0001;
  localparam logic [15:0] STEP_WORD = 16'h0002;
  // working register zero index
  localparam logic [3:0] WORK_REG_ZERO = 4'h0;
  // addressing modes
  typedef enum logic [2:0] {
    OAG_FILE_DIRECT = 3'b000,
    OAG_REG_DIRECT  = 3'b001,
    OAG_INDIRECT    = 3'b010,
    OAG_POST_MOD    = 3'b011,
    OAG_PRE_MOD     = 3'b100,
    OAG_INDEXED     = 3'b101,
    OAG_LIT_OFFSET  = 3'b110,
    OAG_LIT5        = 3'b111
  } oag_mode_e;
endpackage : oag_pkg

//--- logic/oag_core.sv
// operand effective-address and program-space address generator
// Operation
// - file-register field reaches 8192 near bytes only
// - working register zero implied; product writes pair
// - data transfer reaches the whole data space
// - first source is base register, direct only
// - second source register, memory or 5-bit literal
// - indirect uses pointer unchanged as address
// - post-modify accesses, then steps pointer
// - pre-modify steps pointer, writes back, uses it
// - indexed address is pointer plus base register
// - literal offset address is pointer plus literal
// - one 4-bit offset field shared by both sides
// - jump 16-bit signed, hold 14-bit unsigned
// - program 24 bits, data 16, alignment kept
// - table address is table page then address
// - table page top bit selects configuration space
// - address msb set maps through visibility page
// - window addresses keep program bit 23 zero
// - window ignores address bit 15, uses page bit 0
// - window is read-only, low word returned
// - table access reaches every byte everywhere
//
// Local design decisions: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module oag_core (
  input  wire logic        clock,             // core clock
  input  wire logic        rst,               // async reset, high
  // avalon-mm slave
  input  wire logic [3:0]  avs_address,       // byte address
  input  wire logic        avs_read,          // read strobe
  input  wire logic        avs_write,         // write strobe
  input  wire logic [31:0] avs_writedata,     // write data
  output logic      [31:0] avs_readdata,      // read data
  output logic             avs_waitrequest,   // stall
  // request from instruction decode
  input  wire logic        agu_valid,         // one-cycle request
  input  wire logic [2:0]  agu_mode,          // addressing mode
  input  wire logic [15:0] agu_pointer,       // pointer register value
  input  wire logic [15:0] agu_base,          // base operand register value
  input  wire logic [3:0]  agu_base_sel,      // shared 4-bit offset field
  input  wire logic [15:0] agu_literal,       // instruction literal
  input  wire logic        agu_byte,          // byte-sized access
  input  wire logic        agu_decrement,     // step down instead of up
  input  wire logic        agu_full_space,    // data transfer instruction
  input  wire logic        agu_dest_default_accumulator_register,     // result to working reg zero
  input  wire logic        agu_product,       // product instruction
  input  wire logic [3:0]  agu_dest_sel,      // product destination
  input  wire logic        agu_table,         // table read or write
  input  wire logic        agu_write,         // write access
  input  wire logic        agu_table_high,    // table upper byte space
  input  wire logic [23:0] fetch_pc,          // program counter
  // results
  output logic             res_valid,         // one-cycle result strobe
  output logic [15:0]      res_ea,            // data effective address
  output logic             res_data_req,      // data memory access
  output logic             res_wb_valid,      // pointer write back
  output logic [15:0]      res_wb_value,      // new pointer value
  output logic [3:0]       res_src1_sel,      // first source register
  output logic [15:0]      res_operand,       // 5-bit literal or base operand
  output logic             res_operand_lit,   // operand is literal
  output logic [3:0]       res_work_sel,      // implied working register
  output logic             res_dest_reg,      // result goes to register
  output logic             res_dest_pair,     // register pair destination
  output logic [3:0]       res_dest_sel,      // destination register
  output logic             res_prog_req,      // program memory access
  output logic [23:0]      res_prog_addr,     // program address
  output logic             res_prog_cfg,      // configuration space
  output logic             res_prog_high,     // upper byte space
  output logic             res_win_hit,       // access via window
  output logic             res_refused,       // window write refused
  output logic [22:0]      res_jump_ofs,      // sign-extended jump field
  output logic [13:0]      res_hold_cnt,      // hold count field
  output logic [23:0]      fetch_addr,        // instruction fetch address
  // read data path
  input  wire logic [23:0] prog_rdata,        // raw program word
  output logic [15:0]      win_rdata          // word seen through window
);

  // software registers
  logic [7:0]  table_page_register;           // table page
  logic [7:0]  visibility_page_register;      // window page
  logic        win_en;                        // window enable
  logic        refuse_seen;                   // sticky refused write
  // bus handshake
  logic        bus_ack;                       // answer cycle
  logic [31:0] next_readdata;                 // read mux

  // address decode
  wire         bus_req    = avs_read | avs_write;
  wire         sel_table  = (avs_address == oag_pkg::OFS_TABLE_PAGE);
  wire         sel_vis    = (avs_address == oag_pkg::OFS_VIS_PAGE);
  wire         sel_ctl    = (avs_address == oag_pkg::OFS_CONTROL);
  wire         sel_sts    = (avs_address == oag_pkg::OFS_STATUS);
  wire         wr_take    = avs_write & bus_ack;

  // one wait cycle, then the answer; unmapped reads return zero
  assign avs_waitrequest = bus_req & ~bus_ack;

  // step size: byte or word
  wire [15:0] step_mag = agu_byte ? oag_pkg::STEP_BYTE
                                  : oag_pkg::STEP_WORD;
  // signed step, negated for decrement
  wire [15:0] step_sig = agu_decrement ? 16'(~step_mag + 16'h0001)
                                       : step_mag;
  wire [15:0] ptr_stepped = 16'(agu_pointer + step_sig);

  // near-space address from the 13-bit field
  wire [15:0] near_addr = {3'h0, agu_literal[oag_pkg::NEAR_W-1:0]};
  // data transfer takes the full 16-bit address
  wire [15:0] file_addr = agu_full_space ? agu_literal
                                         : near_addr;

  // effective address by mode
  logic [15:0] ea_sel;                        // chosen address
  logic        mem_sel;                       // mode touches memory
  logic        wb_sel;                        // pointer written back
  always_comb
  begin
    ea_sel  = 16'h0000;
    mem_sel = 1'b0;
    wb_sel  = 1'b0;
    unique case (oag_pkg::oag_mode_e'(agu_mode))
      oag_pkg::OAG_FILE_DIRECT:
      begin
        ea_sel  = file_addr;
        mem_sel = 1'b1;
      end
      // register direct: no memory access at all
      oag_pkg::OAG_REG_DIRECT:
      begin
        ea_sel  = 16'h0000;
      end
      oag_pkg::OAG_INDIRECT:
      begin
        ea_sel  = agu_pointer;
        mem_sel = 1'b1;
      end
      oag_pkg::OAG_POST_MOD:
      begin
        ea_sel  = agu_pointer;
        mem_sel = 1'b1;
        wb_sel  = 1'b1;
      end
      oag_pkg::OAG_PRE_MOD:
      begin
        ea_sel  = ptr_stepped;
        mem_sel = 1'b1;
        wb_sel  = 1'b1;
      end
      oag_pkg::OAG_INDEXED:
      begin
        ea_sel  = 16'(agu_pointer + agu_base);
        mem_sel = 1'b1;
      end
      oag_pkg::OAG_LIT_OFFSET:
      begin
        ea_sel  = 16'(agu_pointer + agu_literal);
        mem_sel = 1'b1;
      end
      // literal operand: no memory access
      oag_pkg::OAG_LIT5:
      begin
        ea_sel  = 16'h0000;
      end
    endcase
  end

  // literal operand of a three-operand instruction
  wire is_lit5 = (agu_mode == 3'(oag_pkg::OAG_LIT5));
  wire [15:0] lit5_val = {11'h000, agu_literal[oag_pkg::LIT5_W-1:0]};

  // window hit: memory-mode address msb set, window on, not a table op
  wire win_hit  = mem_sel & ea_sel[15] & win_en & ~agu_table;
  // the window is read-only; a write through it is dropped
  wire win_refuse = win_hit & agu_write;
  wire win_ok     = win_hit & ~agu_write;

  // window program address: bit 23 zero, page, low 15 bits
  wire [23:0] win_addr = {1'b0, visibility_page_register,
                          ea_sel[14:0]};
  // table address: page as upper byte over the 16-bit address
  wire [23:0] tbl_addr = {table_page_register, ea_sel};

  // program space access chosen
  wire        prog_go   = (agu_table & mem_sel) | win_ok;
  wire [23:0] prog_addr = agu_table ? tbl_addr : win_addr;
  // configuration space only reachable by a table access
  wire        prog_cfg  = agu_table &
                          table_page_register[oag_pkg::PAGE_CFG_BIT];

  // data memory access when not diverted to program space
  wire data_go = mem_sel & ~win_hit & ~agu_table;

  // destination selection for file-register style instructions
  wire dest_reg  = agu_dest_default_accumulator_register | agu_product;
  wire [3:0] dest_sel = agu_product ? agu_dest_sel
                                    : oag_pkg::WORK_REG_ZERO;

  // fetch address: pc 22:1 with both ends zeroed
  wire [23:0] fetch_next = {1'b0, fetch_pc[22:1], 1'b0};

  // jump field sign extended, hold count zero extended
  wire [22:0] jump_ext = {{7{agu_literal[oag_pkg::JUMP_W-1]}},
                          agu_literal};
  wire [13:0] hold_fld = agu_literal[oag_pkg::HOLD_W-1:0];

  // software register writes; window and table pages steer decode
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      table_page_register      <= oag_pkg::RST_TABLE_PAGE;
      visibility_page_register <= oag_pkg::RST_VIS_PAGE;
      win_en                   <= oag_pkg::RST_WIN_EN;
    end
    else if (wr_take)
    begin
      if (sel_table)
        table_page_register <= avs_writedata[7:0];
      if (sel_vis)
        visibility_page_register <= avs_writedata[7:0];
      if (sel_ctl)
        win_en <= avs_writedata[oag_pkg::CTL_WIN_EN_BIT];
    end
  end

  // sticky refused-write flag; a new refusal wins over the clear
  wire sts_clear = wr_take & sel_sts & avs_writedata[oag_pkg::STS_WR_REFUSE_BIT];
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      refuse_seen <= 1'b0;
    else if (agu_valid & win_refuse)
      refuse_seen <= 1'b1;
    else if (sts_clear)
      refuse_seen <= 1'b0;
  end

  // read mux; reserved bits read zero
  always_comb
  begin
    next_readdata = 32'h0000_0000;
    if (sel_table)
      next_readdata = {24'h00_0000, table_page_register};
    else if (sel_vis)
      next_readdata = {24'h00_0000, visibility_page_register};
    else if (sel_ctl)
      next_readdata = {31'h0000_0000, win_en};
    else if (sel_sts)
      next_readdata = {5'h00, res_win_hit, res_prog_cfg, refuse_seen,
                       res_prog_addr};
  end

  // bus answer: ack one cycle after the request appears
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      bus_ack      <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end
    else
    begin
      bus_ack <= bus_req & ~bus_ack;
      if (bus_req & ~bus_ack)
        avs_readdata <= next_readdata;
    end
  end

  // result strobe and data-side address
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      res_valid    <= 1'b0;
      res_ea       <= 16'h0000;
      res_data_req <= 1'b0;
      res_wb_valid <= 1'b0;
      res_wb_value <= 16'h0000;
    end
    else
    begin
      res_valid    <= agu_valid;
      res_data_req <= agu_valid & data_go;
      res_wb_valid <= agu_valid & wb_sel;
      if (agu_valid)
      begin
        res_ea       <= ea_sel;
        res_wb_value <= ptr_stepped;
      end
    end
  end

  // operand and destination routing
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      res_src1_sel    <= 4'h0;
      res_operand     <= 16'h0000;
      res_operand_lit <= 1'b0;
      res_work_sel    <= 4'h0;
      res_dest_reg    <= 1'b0;
      res_dest_pair   <= 1'b0;
      res_dest_sel    <= 4'h0;
    end
    else if (agu_valid)
    begin
      // base field feeds first source and the indexed offset
      res_src1_sel    <= agu_base_sel;
      res_operand     <= is_lit5 ? lit5_val : agu_base;
      res_operand_lit <= is_lit5;
      res_work_sel    <= oag_pkg::WORK_REG_ZERO;
      res_dest_reg    <= dest_reg;
      res_dest_pair   <= agu_product;
      res_dest_sel    <= dest_sel;
    end
  end

  // program-space side
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      res_prog_req  <= 1'b0;
      res_prog_addr <= 24'h00_0000;
      res_prog_cfg  <= 1'b0;
      res_prog_high <= 1'b0;
      res_win_hit   <= 1'b0;
      res_refused   <= 1'b0;
    end
    else
    begin
      res_prog_req <= agu_valid & prog_go;
      res_refused  <= agu_valid & win_refuse;
      if (agu_valid)
      begin
        res_prog_addr <= prog_addr;
        res_prog_cfg  <= prog_cfg;
        // upper byte only through the table path
        res_prog_high <= agu_table & agu_table_high;
        res_win_hit   <= win_hit;
      end
    end
  end

  // literal fields and instruction fetch address
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      res_jump_ofs <= 23'h00_0000;
      res_hold_cnt <= 14'h0000;
      fetch_addr   <= 24'h00_0000;
    end
    else
    begin
      fetch_addr <= fetch_next;
      if (agu_valid)
      begin
        res_jump_ofs <= jump_ext;
        res_hold_cnt <= hold_fld;
      end
    end
  end

  // window read data: only the low word of the program word
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      win_rdata <= 16'h0000;
    else
      win_rdata <= prog_rdata[15:0];
  end

endmodule : oag_core

//--- tb/oag_mem_model.sv
// program memory stand-in on the far side of the generator
`timescale 1ns/100ps
module oag_mem_model (
  input  wire logic        clock,         // core clock
  input  wire logic        res_prog_req,  // program access strobe
  input  wire logic [23:0] res_prog_addr, // program address
  output logic      [23:0] prog_rdata     // full program word
);
  initial prog_rdata = 24'h000000;
  // full 24-bit word from the address; idle cycles flip the bus so stale data never matches
  always @(posedge clock)
  begin
    if (res_prog_req)
      prog_rdata <= {res_prog_addr[7:0] ^ 8'ha5, res_prog_addr[15:0] ^ 16'h3c3c};
    else
      prog_rdata <= ~prog_rdata;
  end
endmodule : oag_mem_model

//--- tb/oag_core_asserts.sv
// timing checks on the address generator ports
`timescale 1ns/100ps
module oag_core_asserts (
  input wire logic        clock, rst, agu_valid, agu_byte, agu_decrement, agu_full_space,
  input wire logic        agu_product, agu_table, agu_write, res_valid, res_wb_valid,
  input wire logic        res_operand_lit, res_dest_reg, res_dest_pair, res_prog_req,
  input wire logic        res_prog_cfg, res_win_hit, res_refused, res_prog_high, agu_table_high,
  input wire logic [2:0]  agu_mode,
  input wire logic [3:0]  agu_base_sel, agu_dest_sel, res_src1_sel, res_work_sel, res_dest_sel,
  input wire logic [15:0] agu_pointer, agu_base, agu_literal, res_ea, res_wb_value,
  input wire logic [15:0] res_operand, win_rdata,
  input wire logic [22:0] res_jump_ofs,
  input wire logic [13:0] res_hold_cnt,
  input wire logic [23:0] fetch_pc, fetch_addr, prog_rdata, res_prog_addr
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // pointer step and stepped pointer
  wire [15:0] stp = agu_byte ? oag_pkg::STEP_BYTE : oag_pkg::STEP_WORD;
  wire [15:0] nxt = agu_decrement ? agu_pointer - stp : agu_pointer + stp;
  // one-hot request per mode
  wire [7:0]  vm  = {8{agu_valid}} & (8'h01 << agu_mode);
  indirect_ea_a: assert property (vm[2] |=> res_ea == $past(agu_pointer))
    else $error("indirect address wrong");
  post_mod_a: assert property (vm[3] |=> res_ea == $past(agu_pointer) && res_wb_valid
    && res_wb_value == $past(nxt)) else $error("post modify wrong");
  pre_mod_a: assert property (vm[4] |=> res_ea == $past(nxt) && res_wb_valid
    && res_wb_value == res_ea) else $error("pre modify wrong");
  indexed_ea_a: assert property (vm[5] |=> res_ea == $past(16'(agu_pointer + agu_base)))
    else $error("indexed address wrong");
  lit_offset_a: assert property (vm[6] |=>
    res_ea == $past(16'(agu_pointer + agu_literal))) else $error("literal offset wrong");
  near_field_a: assert property (vm[0] |=> res_ea == ($past(agu_full_space) ?
    $past(agu_literal) : {3'h0, $past(agu_literal[12:0])})) else $error("direct field wrong");
  src_select_a: assert property (agu_valid |=> res_src1_sel == $past(agu_base_sel)
    && res_work_sel == oag_pkg::WORK_REG_ZERO) else $error("source select wrong");
  lit5_operand_a: assert property (vm[7] |=> res_operand_lit
    && res_operand == {11'h000, $past(agu_literal[4:0])}) else $error("short literal wrong");
  product_dest_a: assert property (agu_valid && agu_product |=> res_dest_pair
    && res_dest_reg && res_dest_sel == $past(agu_dest_sel)) else $error("product dest wrong");
  literal_fields_a: assert property (agu_valid |=>
    res_hold_cnt == $past(agu_literal[13:0])
    && res_jump_ofs == {{7{$past(agu_literal[15])}}, $past(agu_literal)})
    else $error("literal fields wrong");
  table_addr_a: assert property (agu_valid && agu_table |=> res_prog_req
    && !res_win_hit
    && res_prog_addr[15:0] == res_ea && res_prog_cfg == res_prog_addr[23])
    else $error("table address wrong");
  // upper byte space is reached only through a table access
  table_high_a: assert property (agu_valid |=>
    res_prog_high == $past(agu_table && agu_table_high)) else $error("upper byte select wrong");
  window_map_a: assert property (res_valid && res_win_hit |-> res_ea[15]
    && !res_prog_addr[23] && res_prog_addr[14:0] == res_ea[14:0]) else $error("window map wrong");
  window_ro_a: assert property (agu_valid && agu_write && !agu_table |=>
    res_refused == res_win_hit && !(res_refused && res_prog_req)) else $error("window write wrong");
  low_word_a: assert property (!$past(rst) |-> win_rdata == $past(prog_rdata[15:0]))
    else $error("window data wrong");
  fetch_addr_a: assert property (!$past(rst) |->
    fetch_addr == {1'b0, $past(fetch_pc[22:1]), 1'b0}) else $error("fetch address wrong");
  // main scenarios reached
  cover property (vm[4]);
  cover property (res_win_hit && res_refused);
  cover property (res_valid && res_prog_cfg);
endmodule : oag_core_asserts
bind oag_core oag_core_asserts u_chk (.*);

//--- tb/oag_core_tb_top.sv
// self-checking bench for the address generator
`timescale 1ns/100ps
module oag_core_tb_top;
  logic clock, rst, avs_read, avs_write, avs_waitrequest, agu_valid, agu_byte, agu_decrement;
  logic agu_full_space, agu_dest_default_accumulator_register, agu_product, agu_table, agu_write, agu_table_high;
  logic res_valid, res_data_req, res_wb_valid, res_operand_lit, res_dest_reg, res_dest_pair;
  logic res_prog_req, res_prog_cfg, res_prog_high, res_win_hit, res_refused;
  logic [2:0]  agu_mode;
  logic [3:0]  avs_address, agu_base_sel, agu_dest_sel, res_src1_sel, res_work_sel, res_dest_sel;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [15:0] agu_pointer, agu_base, agu_literal, res_ea, res_wb_value, res_operand, win_rdata;
  logic [23:0] fetch_pc, res_prog_addr, fetch_addr, prog_rdata;
  logic [22:0] res_jump_ofs;
  logic [13:0] res_hold_cnt;
  logic [63:0] eq[$], mq[$];   // expected results and compare masks
  logic [63:0] got;            // packed result fields seen at a strobe
  int          num_errors, samples_checked, seed;
  oag_core u_dut (.*);
  oag_mem_model u_mem (.clock(clock), .res_prog_req(res_prog_req),
    .res_prog_addr(res_prog_addr), .prog_rdata(prog_rdata));
  initial
  begin
    clock = 0;
    forever #2 clock = ~clock;
  end
  // compare one value and count it
  task chk(input logic [63:0] a, input logic [63:0] e);
    samples_checked++;
    if (a !== e)
    begin
      num_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, a, e);
    end
  endtask : chk
  // avalon cycle, held until waitrequest is seen low
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clock);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0) @(posedge clock);
    r = avs_readdata;
    avs_write <= 0;
    avs_read <= 0;
  endtask : bus
  task summarize;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize
  // random program counter value on every clock
  always @(posedge clock) fetch_pc <= $random(seed);
  // result watcher: oldest note against each result strobe
  always @(posedge clock)
  begin
    if (res_valid === 1'b1)
    begin
      samples_checked++;
      got = {res_ea, res_prog_addr, res_wb_value, res_prog_req, res_win_hit, res_refused,
        res_prog_cfg, res_data_req, res_wb_valid, res_operand_lit, res_dest_pair};
      if (eq.size() == 0 || (((got ^ eq[0]) & mq[0]) !== 64'h0))
      begin
        num_errors++;
        $display("ERROR t=%0t got %h exp %h", $time, got, eq.size() ? eq[0] : 64'h0);
      end
      if (eq.size())
      begin
        void'(eq.pop_front());
        void'(mq.pop_front());
      end
    end
  end
  initial
  begin
    repeat (5000) @(posedge clock);
    num_errors++;
    summarize();
  end
  initial
  begin : main
    logic [2:0] m;
    logic [15:0] p, b, l, ea, nx, f;
    logic [7:0] pg;
    logic en, tb, mem, hit, pr;
    int nref;
    seed = 25;
    {rst, avs_read, avs_write, agu_valid, agu_byte, agu_decrement, agu_full_space} = 7'h40;
    {agu_dest_default_accumulator_register, agu_product, agu_table, agu_write, agu_table_high} = 5'h00;
    {agu_mode, avs_address, agu_base_sel, agu_dest_sel, avs_writedata} = 47'h0;
    {agu_pointer, agu_base, agu_literal} = 48'h0;
    repeat (12) @(posedge clock);
    rst <= 0;
    // reset values and the unmapped hole
    for (int a = 0; a < 12; a += 4)
    begin
      bus(0, a, 0, q);
      chk(q, 0);
    end
    bus(1, 4'h2, 32'hffffffff, q);
    bus(0, 4'h2, 0, q);
    chk(q, 0);
    for (int pass = 0; pass < 2; pass++)
    begin
      pg = pass ? 8'h05 : 8'h85;
      en = !pass;
      bus(1, oag_pkg::OFS_TABLE_PAGE, pg, q);
      bus(1, oag_pkg::OFS_VIS_PAGE, 8'h3d, q);
      bus(1, oag_pkg::OFS_CONTROL, en, q);
      bus(0, oag_pkg::OFS_TABLE_PAGE, 0, q);
      chk(q, pg);
      bus(0, oag_pkg::OFS_VIS_PAGE, 0, q);
      chk(q, 8'h3d);
      nref = 0;
      // back-to-back random requests over every mode
      for (int i = 0; i < 60; i++)
      begin
        @(posedge clock);
        m = $random(seed);
        {p, b, l, f} = {$random(seed), $random(seed)};
        if (m == 3'h0)
          l[15] = 0;
        mem = m != 3'h1 && m != 3'h7;
        tb = f[0] && mem;
        nx = f[3] ? p - (f[2] ? 16'h1 : 16'h2) : p + (f[2] ? 16'h1 : 16'h2);
        case (m)
          3'h0: ea = f[4] ? l : {3'h0, l[12:0]};
          3'h4: ea = nx;
          3'h5: ea = p + b;
          3'h6: ea = p + l;
          default: ea = p;
        endcase
        hit = mem & ea[15] & en & ~tb;
        pr = tb | (hit & ~f[1]);
        nref += hit & f[1];
        agu_valid <= 1;
        {agu_mode, agu_pointer, agu_base, agu_literal} <= {m, p, b, l};
        // write f1, byte f2, decrement f3, full space f4, as the expectation uses them
        {agu_table, agu_write, agu_byte, agu_decrement, agu_full_space} <= {tb, f[1], f[2], f[3], f[4]};
        {agu_product, agu_dest_default_accumulator_register, agu_table_high, agu_base_sel, agu_dest_sel} <= f[15:5];
        eq.push_back({ea, tb ? {pg, ea} : {1'b0, 8'h3d, ea[14:0]}, nx, pr, hit, hit & f[1],
          tb & pg[7], mem & ~hit & ~tb, m == 3'h3 || m == 3'h4, m == 3'h7, f[15]});
        mq.push_back({mem ? 16'hffff : 16'h0, pr ? 24'hffffff : 24'h0, 24'hffffff});
      end
      @(posedge clock);
      agu_valid <= 0;
      repeat (3) @(posedge clock);
      // sticky refused-write flag, then write one to clear
      bus(0, oag_pkg::OFS_STATUS, 0, q);
      chk(q[24], nref != 0);
      bus(1, oag_pkg::OFS_STATUS, 32'h01000000, q);
      bus(0, oag_pkg::OFS_STATUS, 0, q);
      chk(q[24], 0);
    end
    chk(eq.size(), 0);
    summarize();
  end
endmodule : oag_core_tb_top
